// ---- design/cls_pkg.sv ----
package cls_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 320;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int USER_WAIT_US = 25;
  localparam int USER_WAIT_CYC = (USER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_WAIT_NS = 1200;
  localparam int DATA_WAIT_CYC = (DATA_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAIN_BITS = 1344;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_WAIT = 4'h8;
  localparam logic [3:0] REG_BITS = 4'hC;
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_BY_EIGHT_BIT = 1;
  localparam int CTRL_CHAIN_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_JTAG_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // divider half periods minus one, in system cycles (divide by four / eight)
  localparam logic [2:0] HALF_BY_FOUR = 3'h1;
  localparam logic [2:0] HALF_BY_EIGHT = 3'h3;

  typedef enum logic [2:0] {
    CLS_IDLE = 3'b000,
    CLS_RESET = 3'b001,
    CLS_DATA_WAIT = 3'b010,
    CLS_LOAD = 3'b011,
    CLS_USER_WAIT = 3'b100,
    CLS_USER = 3'b101
  } cls_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } cls_bus_t;

endpackage

// ---- design/cls_clkdiv.sv ----
`timescale 1ns/1ps
// configuration clock divider: toggles every half period while enabled
module cls_clkdiv (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] half_i,
  // divided clock and its rising-edge enable
  output logic config_clock_o,
  output logic rise_o
);
  logic [2:0] cnt;

  // counter restarts when stopped so the first edge is a full phase away
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 3'h0;
      config_clock_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= 3'h0;
      config_clock_o <= 1'b0;
    end else if (cnt == half_i) begin
      cnt <= 3'h0;
      config_clock_o <= ~config_clock_o;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // one-cycle pulse in the cycle before the output goes high
  assign rise_o = run_i && (cnt == half_i) && !config_clock_o;
endmodule

// ---- design/cls_top.sv ----
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
// What this block does
// - after the done flag rises, at least 25 us pass before user mode is declared.
// - in active mode the config clock is the system clock divided by four or by eight.
// - over boundary scan the wait starts only with done high and enter-user received.
// - a parallel chain of width two or four forces the divide-by-four setting.
module cls_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // configuration pins
  input wire logic creset_n_i,
  input wire logic passive_clock_i,
  input wire logic data_i,
  input wire logic config_done_flag_i,
  input wire logic enter_user_mode_instruction_i,
  output logic config_clock_o,
  output logic config_clock_oe_o,
  // status
  output logic user_mode_o,
  output logic system_reset_n_o,
  output logic data_bit_o,
  output logic data_valid_o
);
  cls_pkg::cls_bus_t bus;
  cls_pkg::cls_state_t state;
  logic active_mode;
  logic active_clock_divide_by_eight;
  logic chain_narrow;
  logic jtag_path;
  logic [1:0] rst_sync;
  logic [1:0] pclk_sync;
  logic [1:0] dat_sync;
  logic [1:0] done_sync;
  logic [1:0] eu_sync;
  logic pclk_d;
  logic [cls_pkg::CNT_W-1:0] cnt;
  logic [31:0] bit_count;
  logic user_pulse_seen;
  logic div_run;
  logic div_rise;
  logic [2:0] half;
  logic sample;
  logic reset_done;
  cls_pkg::cls_state_t resume_state;
  logic user_hold;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h3;
      pclk_sync <= 2'h0;
      dat_sync <= 2'h0;
      done_sync <= 2'h0;
      eu_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], creset_n_i};
      pclk_sync <= {pclk_sync[0], passive_clock_i};
      dat_sync <= {dat_sync[0], data_i};
      done_sync <= {done_sync[0], config_done_flag_i};
      eu_sync <= {eu_sync[0], enter_user_mode_instruction_i};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_mode <= cls_pkg::CTRL_RESET[cls_pkg::CTRL_ACTIVE_BIT];
      active_clock_divide_by_eight <= cls_pkg::CTRL_RESET[cls_pkg::CTRL_BY_EIGHT_BIT];
      chain_narrow <= cls_pkg::CTRL_RESET[cls_pkg::CTRL_CHAIN_BIT];
      jtag_path <= 1'b0;
    end else if (bus.wr && bus.addr == cls_pkg::REG_CTRL) begin
      active_mode <= bus.wdata[cls_pkg::CTRL_ACTIVE_BIT];
      active_clock_divide_by_eight <= bus.wdata[cls_pkg::CTRL_BY_EIGHT_BIT];
      chain_narrow <= bus.wdata[cls_pkg::CTRL_CHAIN_BIT];
      jtag_path <= bus.wdata[cls_pkg::CTRL_JTAG_BIT];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        cls_pkg::REG_CTRL: begin
          rdata_o <= {27'h0, jtag_path, 1'b0, chain_narrow, active_clock_divide_by_eight,
            active_mode};
        end
        cls_pkg::REG_STATUS: rdata_o <= {24'h0, user_mode_o, done_sync[1], 3'h0, state};
        cls_pkg::REG_WAIT: rdata_o <= {{(32 - cls_pkg::CNT_W){1'b0}}, cnt};
        cls_pkg::REG_BITS: rdata_o <= bit_count;
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  // narrow parallel chains cannot run at divide-by-eight, so the bit is overridden
  assign half = (active_clock_divide_by_eight && !chain_narrow) ?
    cls_pkg::HALF_BY_EIGHT : cls_pkg::HALF_BY_FOUR;
  assign div_run = active_mode && (state == cls_pkg::CLS_LOAD);

  cls_clkdiv u_div (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(div_run),
    .half_i(half),
    .config_clock_o(config_clock_o),
    .rise_o(div_rise)
  );

  // active drives the clock pin, passive leaves it to the host
  assign config_clock_oe_o = active_mode;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= pclk_sync[1];
    end
  end

  // rising edge of whichever clock is in charge samples a bit
  assign sample = active_mode ? div_rise : (pclk_sync[1] && !pclk_d);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign reset_done = (cnt >= cls_pkg::CNT_W'(cls_pkg::RESET_MIN_CYC - 1));

  // the reset pin interrupts any state; where it was is kept so a short glitch returns there, with any wait count restarted
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= cls_pkg::CLS_IDLE;
      resume_state <= cls_pkg::CLS_IDLE;
      cnt <= '0;
      user_pulse_seen <= 1'b0;
    end else if (!rst_sync[1] && (state != cls_pkg::CLS_RESET)) begin
      resume_state <= state;
      state <= cls_pkg::CLS_RESET;
      cnt <= '0;
    end else begin
      case (state)
        cls_pkg::CLS_IDLE, cls_pkg::CLS_USER: begin
          cnt <= '0;
        end
        cls_pkg::CLS_RESET: begin
          // short pulses go back where they came from; a restarted wait only grows longer
          if (rst_sync[1]) begin
            state <= reset_done ? cls_pkg::CLS_DATA_WAIT : resume_state;
            cnt <= '0;
          end else if (!reset_done) begin
            cnt <= cnt + 1'b1;
          end
        end
        cls_pkg::CLS_DATA_WAIT: begin
          // an enter-user seen before this reset must not count for the new load
          user_pulse_seen <= 1'b0;
          // data before this point is the host's fault; it is simply not taken
          if (cnt == cls_pkg::CNT_W'(cls_pkg::DATA_WAIT_CYC - 1)) begin
            state <= cls_pkg::CLS_LOAD;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        cls_pkg::CLS_LOAD: begin
          user_pulse_seen <= user_pulse_seen | eu_sync[1];
          // over boundary scan the wait also needs the enter-user instruction
          if (done_sync[1] && (!jtag_path || user_pulse_seen || eu_sync[1])) begin
            state <= cls_pkg::CLS_USER_WAIT;
            cnt <= '0;
          end
        end
        cls_pkg::CLS_USER_WAIT: begin
          user_pulse_seen <= 1'b0;
          if (cnt == cls_pkg::CNT_W'(cls_pkg::USER_WAIT_CYC - 1)) begin
            state <= cls_pkg::CLS_USER;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= cls_pkg::CLS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data capture and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_bit_o <= 1'b0;
      data_valid_o <= 1'b0;
      bit_count <= 32'h0000_0000;
    end else begin
      data_valid_o <= (state == cls_pkg::CLS_LOAD) && sample;
      if ((state == cls_pkg::CLS_LOAD) && sample) begin
        data_bit_o <= dat_sync[1];
        bit_count <= bit_count + 32'h0000_0001;
      end else if (state == cls_pkg::CLS_DATA_WAIT) begin
        bit_count <= 32'h0000_0000;
      end
    end
  end

  // a reset still being qualified does not end user mode, so a short glitch is invisible
  assign user_hold = (state == cls_pkg::CLS_USER) ||
    ((state == cls_pkg::CLS_RESET) && (resume_state == cls_pkg::CLS_USER) && !reset_done);

  // system logic stays in reset until the whole wait is over
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      user_mode_o <= 1'b0;
      system_reset_n_o <= 1'b0;
    end else begin
      user_mode_o <= user_hold;
      system_reset_n_o <= user_hold;
    end
  end
endmodule

// ---- tb/cls_top_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module cls_top_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // pins and status
  input wire logic creset_n_i,
  input wire logic config_done_flag_i,
  input wire logic config_clock_o,
  input wire logic config_clock_oe_o,
  input wire logic user_mode_o,
  input wire logic system_reset_n_o,
  input wire logic data_valid_o
);
  logic eight_q;
  logic act_q;
  // shadow of the mode bits; narrow chain wins over divide by eight
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eight_q <= 1'b0;
      act_q <= 1'b0;
    end else if (wr_i && addr_i == cls_pkg::REG_CTRL) begin
      eight_q <= wdata_i[cls_pkg::CTRL_BY_EIGHT_BIT] && !wdata_i[cls_pkg::CTRL_CHAIN_BIT];
      act_q <= wdata_i[cls_pkg::CTRL_ACTIVE_BIT];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside a read cycle");
  a_oe_mode: assert property (config_clock_oe_o == act_q)
    else $error("clock enable does not follow the mode");
  // a reset pin already low may cut the phase short, so such rises are left out
  a_clk_by_four: assert property ($rose(config_clock_o) && !eight_q && creset_n_i
    && !config_done_flag_i |-> ##2 !config_clock_o)
    else $error("clock high too long for divide by four");
  a_clk_by_eight: assert property ($rose(config_clock_o) && eight_q && creset_n_i
    && !config_done_flag_i |-> ##2 config_clock_o)
    else $error("clock high too short for divide by eight");
  a_valid_pulse: assert property (data_valid_o |=> !data_valid_o)
    else $error("data valid longer than one cycle");
  a_early_data: assert property ($rose(creset_n_i) |-> !data_valid_o [*8])
    else $error("data taken during the data wait");
  a_short_reset: assert property (user_mode_o && $fell(creset_n_i) |-> user_mode_o [*6])
    else $error("short reset pulse left user mode");
  a_user_wait: assert property ($rose(user_mode_o) |-> $past(config_done_flag_i, 620))
    else $error("user mode too soon after done");
  a_sysrst_rise: assert property ($rose(user_mode_o) |-> ##[0:1] system_reset_n_o)
    else $error("system reset not released with user mode");
  a_sysrst_hold: assert property (!user_mode_o ##1 !user_mode_o |-> !system_reset_n_o)
    else $error("system reset released before user mode");
  c_user: cover property ($rose(user_mode_o));
  c_by_eight: cover property ($rose(config_clock_o) && eight_q);
  c_passive_bit: cover property (data_valid_o && !config_clock_oe_o);
endmodule

bind cls_top cls_top_props u_props (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .creset_n_i(creset_n_i),
  .config_done_flag_i(config_done_flag_i),
  .config_clock_o(config_clock_o),
  .config_clock_oe_o(config_clock_oe_o),
  .user_mode_o(user_mode_o),
  .system_reset_n_o(system_reset_n_o),
  .data_valid_o(data_valid_o)
);

// ---- tb/cls_flash_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial flash on the active-mode side
// ----------------------------------------------------------------
module cls_flash_model (
  // clock from the device and select
  input wire logic config_clock_i,
  input wire logic select_i,
  // serial data towards the device
  output logic data_o
);
  logic [15:0] image = 16'hA5C3;
  // shift on the falling edge so the bit is settled at the rising edge
  always @(negedge config_clock_i) begin
    image <= {image[14:0], image[15]};
  end
  // deselected flash releases the line: show the inverse, not a stale bit
  assign data_o = select_i ? image[15] : ~image[15];
endmodule

// ---- tb/cls_top_tb_top.sv ----
`timescale 1ns/1ps
module cls_top_tb_top;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic creset_n_i = 1'b1;
  logic pclk = 1'b0;
  logic hdata = 1'b0;
  logic done = 1'b0;
  logic enter = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] rdata_o;
  logic cclk, oe, umode, srst_n, dbit, dvalid, fdata, b, prev;
  integer seed = 46;
  int err_count = 0;
  int n_compared = 0;
  int t, n;
  logic [31:0] rq[$];
  logic bq[$];
  logic [31:0] ctl[3] = '{32'h1, 32'h3, 32'h7};
  cls_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .creset_n_i(creset_n_i),
    .passive_clock_i(pclk), .data_i(oe ? fdata : hdata), .config_done_flag_i(done),
    .enter_user_mode_instruction_i(enter), .config_clock_o(cclk), .config_clock_oe_o(oe),
    .user_mode_o(umode), .system_reset_n_o(srst_n), .data_bit_o(dbit), .data_valid_o(dvalid));
  cls_flash_model u_flash (.config_clock_i(cclk), .select_i(oe), .data_o(fdata));
  initial forever #20 clock_i = ~clock_i;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
  endtask
  // expected read data is queued here and compared by the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    rq.push_back(e);
    cyc(1);
    rd_i <= 1'b0;
    cyc(1);
  endtask
  task automatic pulse(input int k);
    creset_n_i <= 1'b0;
    cyc(k);
    creset_n_i <= 1'b1;
    cyc(3);
  endtask
  // bounded wait; running out ends the run
  task automatic wait_user;
    t = 0;
    while (!umode && t < 800) begin
      cyc(1);
      t++;
    end
    check("user_wait", {31'h0, t >= 625 && t < 800}, 32'h1);
    if (t >= 800) summarize();
  endtask
  // monitor: results take the oldest note off their queue
  always @(posedge clock_i) begin
    rd_q <= rd_i;
    if (rd_q) check("rdata", rdata_o, rq.pop_front());
    if (dvalid && bq.size() > 0) check("data_bit", {31'h0, dbit}, {31'h0, bq.pop_front()});
  end
  initial begin
    cyc(10);
    nrst_i <= 1'b1;
    cyc(2);
    rd(cls_pkg::REG_CTRL, cls_pkg::CTRL_RESET);
    wr(4'h2, $random(seed));
    rd(4'h2, 32'h0);
    pulse(4);
    rd(cls_pkg::REG_STATUS, 32'h0);
    pulse(10);
    cyc(16);
    rd(cls_pkg::REG_STATUS, 32'h2);
    $display("test registers and reset done");
    cyc(15);
    // slow host clock with equal phases, data set while low
    repeat (8) begin
      b = $random(seed);
      hdata <= b;
      bq.push_back(b);
      cyc(4);
      pclk <= 1'b1;
      cyc(4);
      pclk <= 1'b0;
    end
    done <= 1'b1;
    wait_user();
    cyc(2);
    check("sys_reset_n", {31'h0, srst_n}, 32'h1);
    rd(cls_pkg::REG_STATUS, 32'hC5);
    rd(cls_pkg::REG_BITS, 32'h8);
    pulse(4);
    check("short_pulse", {31'h0, umode}, 32'h1);
    $display("test passive load done");
    done <= 1'b0;
    // active mode: count clock rises over sixteen cycles per setting
    // settings change during the data wait, never under a running clock
    for (int i = 0; i < 3; i++) begin
      pulse(10);
      wr(cls_pkg::REG_CTRL, ctl[i]);
      cyc(40);
      n = 0;
      prev = cclk;
      repeat (16) begin
        cyc(1);
        if (cclk && !prev) n++;
        prev = cclk;
      end
      check("clock_rises", n, (i == 1) ? 2 : 4);
    end
    $display("test active clock done");
    pulse(10);
    wr(cls_pkg::REG_CTRL, 32'h10);
    cyc(40);
    done <= 1'b1;
    cyc(700);
    check("no_enter_user", {31'h0, umode}, 32'h0);
    enter <= 1'b1;
    cyc(2);
    enter <= 1'b0;
    wait_user();
    pulse(10);
    check("restart", {31'h0, umode}, 32'h0);
    check("bits_left", bq.size(), 0);
    $display("test boundary scan path done");
    summarize();
  end
endmodule
